// ### rtl/switch_link_error_handler.sv
`timescale 1ns/1ns
// Contract
// - Line error resets link at least 256 cycles
// - Flag phase loss and illegal symbols
// - Route byte parity mismatch flags and terminates
// - Parity abort: NACK, discard, forward bad end
// - Check CCITT CRC of every transaction
// - CRC flag on mismatch or premature end
// - Transaction length from first byte bits 6:4
// - CRC flagging can be disabled by test port
// - CRC abort: consume, bad end, NACK if unacknowledged
// - Flag CRC even if packet already left
// - Open timeout resets output, flags input
// - Wait control bit0: gobble, NACK, forward nothing
// - Wait control bit1: flag only, packet continues
// - Chip reset clears wait control bits
// - Wait period from 3-bit global code, doubling
// - Received RESET propagates if inside a packet; output sends one RESET
// - Reset output ignores credit 64 cycles
// - Input flushes, holds credit 256 cycles
// - Timeout reset affects one direction only
// - Hard errors and resets reset both directions
// - Disabled link sends RESET, PACKs routed packets
// - Sticky flags, cleared by test port, ORed
module switch_link_error_handler
	import link_err_pkg::*;
#(
	parameter int CNT_W = 24,
	parameter int OPEN_LIMIT = int'(OPEN_TIMEOUT_CYCLES),
	parameter int WAIT_BASE = int'(WAIT_BASE_CYCLES)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic linkClk,
	input wire logic [SYM_W-1:0] rxSymbol,
	input wire logic rxPhaseSlip,
	input wire logic inputOpen,
	input wire logic inputWaiting,
	input wire logic ackReturned,
	input wire logic xbarResetIn,
	input wire logic tapWaitCtrlWe,
	input wire logic [1:0] tapWaitCtrlIn,
	input wire logic tapGlobalWe,
	input wire logic [3:0] tapGlobalIn,
	input wire logic [ERR_W-1:0] tapErrClr,
	input wire logic tapLinkReset,
	input wire logic tapLinkDisable,
	output logic fwdValid,
	output logic [SYM_W-1:0] fwdSymbol,
	output logic nackToSender,
	output logic xbarResetOut,
	output logic inFlush,
	output logic creditHold,
	output logic outLinkReset,
	output logic txResetHold,
	output logic txResetOnce,
	output logic creditClear,
	output logic tokenIgnore,
	output logic disabledPack,
	output logic [1:0] waitCtrl,
	output logic [3:0] globalCfg,
	output logic [ERR_W-1:0] errFlags,
	output logic errorN
);
	function automatic logic [7:0] sym_to_byte(input logic [SYM_W-1:0] s);
		logic [1:0] hi;
		hi = BYTE_HI_0;
		unique case (s[8:6])
			DATA_TOP_1: hi = BYTE_HI_1;
			DATA_TOP_2: hi = BYTE_HI_2;
			DATA_TOP_3: hi = BYTE_HI_3;
			default: hi = BYTE_HI_0;
		endcase
		sym_to_byte = {hi, s[5:0]};
	endfunction : sym_to_byte

	function automatic logic sym_is_data(input logic [SYM_W-1:0] s);
		sym_is_data = s[8:6] == DATA_TOP_0 || s[8:6] == DATA_TOP_1 || s[8:6] == DATA_TOP_2 || s[8:6] == DATA_TOP_3;
	endfunction : sym_is_data

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		crc_byte = r;
	endfunction : crc_byte

	// ---------------- Link clock domain ----------------
	logic linkRstA_q, linkRstB_q;
	logic [SYM_W-1:0] rxA_q, rxB_q, holdSym_q;
	logic phA_q, phB_q, ackA_q, ackB_q;
	logic reqT_q, dErrT_q, pErrT_q, ackT_q;

	always_ff @(posedge linkClk) begin
		linkRstA_q <= rst_n;
		linkRstB_q <= linkRstA_q;
	end

	always_ff @(posedge linkClk) begin
		rxA_q <= rxSymbol;
		rxB_q <= rxA_q;
		phA_q <= rxPhaseSlip;
		phB_q <= phA_q;
		ackA_q <= ackT_q;
		ackB_q <= ackA_q;
	end

	wire rxIsCmd = rxB_q[8:6] == CMD_TOP && rxB_q[5:3] == rxB_q[2:0];
	wire rxIllegal = !rxIsCmd && !sym_is_data(rxB_q);
	wire rxKeep = sym_is_data(rxB_q) || rxB_q == CMD_SOP || rxB_q == CMD_EOP || rxB_q == CMD_RESET;
	wire linkIdle = reqT_q == ackB_q;

	always_ff @(posedge linkClk) begin
		if (!linkRstB_q) begin
			reqT_q <= 1'b0;
			holdSym_q <= CMD_NULL;
			dErrT_q <= 1'b0;
			pErrT_q <= 1'b0;
		end else begin
			if (rxKeep && linkIdle) begin
				holdSym_q <= rxB_q;
				reqT_q <= ~reqT_q;
			end
			if (rxIllegal) begin
				dErrT_q <= ~dErrT_q;
			end
			if (phB_q) begin
				pErrT_q <= ~pErrT_q;
			end
		end
	end

	// ---------------- Core clock domain ----------------
	logic reqA_q, reqB_q, reqC_q, dA_q, dB_q, dC_q, pA_q, pB_q, pC_q;

	always_ff @(posedge clk) begin
		reqA_q <= reqT_q;
		reqB_q <= reqA_q;
		reqC_q <= reqB_q;
		dA_q <= dErrT_q;
		dB_q <= dA_q;
		dC_q <= dB_q;
		pA_q <= pErrT_q;
		pB_q <= pA_q;
		pC_q <= pB_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) ackT_q <= 1'b0;
		else ackT_q <= reqB_q;
	end

	wire symStb = reqB_q ^ reqC_q;
	wire dataErr = dB_q ^ dC_q;
	wire phaseErr = pB_q ^ pC_q;
	wire [7:0] rxByte = sym_to_byte(holdSym_q);
	wire isData = symStb && sym_is_data(holdSym_q);
	wire isSop = symStb && holdSym_q == CMD_SOP;
	wire isEop = symStb && holdSym_q == CMD_EOP;
	wire isRst = symStb && holdSym_q == CMD_RESET;

	// Configuration reached through the test port
	logic [1:0] waitCtrl_q;
	logic [3:0] globalCfg_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitCtrl_q <= WAIT_CTRL_RESET;
			globalCfg_q <= GLOBAL_CFG_RESET;
		end else begin
			if (tapWaitCtrlWe) waitCtrl_q <= tapWaitCtrlIn;
			if (tapGlobalWe) globalCfg_q <= tapGlobalIn;
		end
	end

	wire crcEn = !globalCfg_q[CFG_CRC_DIS_BIT];

	// Both-direction link reset
	logic [8:0] lineCnt_q;
	wire lineErr = dataErr || phaseErr;
	wire hardReset = lineErr || tapLinkReset;
	wire inLineReset = lineCnt_q != 9'h000;
	wire [8:0] lineCnt_d = hardReset ? 9'(LINE_RESET_CYCLES) : (inLineReset ? lineCnt_q - 9'h001 : lineCnt_q);

	// Receive packet tracking
	rx_state_type state_q, state_d;
	logic [9:0] byteCnt_q, byteCnt_d, transLen_q, transLen_d;
	logic [15:0] crc_q, crc_d;
	logic inPkt_q, inPkt_d;
	logic routeParErr, crcErr, premature, waitGobble, abortBad;

	wire [15:0] crcNext = crc_byte(crc_q, rxByte);
	wire transDone = byteCnt_q + 10'h001 == transLen_q;

	// Waiting and open timers
	logic [CNT_W-1:0] openCnt_q, waitCnt_q;
	wire [CNT_W-1:0] openLimit = CNT_W'(OPEN_LIMIT);
	wire [CNT_W-1:0] waitLimit = CNT_W'(WAIT_BASE) << globalCfg_q[2:0];
	wire openFire = inputOpen && openCnt_q == openLimit - CNT_W'(1);
	wire waitFire = inputWaiting && waitCnt_q == waitLimit - CNT_W'(1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			openCnt_q <= '0;
			waitCnt_q <= '0;
		end else begin
			openCnt_q <= !inputOpen ? '0 : (openCnt_q == openLimit ? openCnt_q : openCnt_q + CNT_W'(1));
			waitCnt_q <= !inputWaiting ? '0 : (waitCnt_q == waitLimit ? waitCnt_q : waitCnt_q + CNT_W'(1));
		end
	end

	always_comb begin
		state_d = state_q;
		byteCnt_d = byteCnt_q;
		transLen_d = transLen_q;
		crc_d = crc_q;
		inPkt_d = inPkt_q;
		routeParErr = 1'b0;
		crcErr = 1'b0;
		premature = 1'b0;
		waitGobble = 1'b0;
		if (inLineReset || isRst) begin
			state_d = ST_ROUTE;
			inPkt_d = 1'b0;
		end else begin
			if (symStb) inPkt_d = !isEop;
			unique case (state_q)
				ST_ROUTE: begin
					if (isData && ^rxByte == 1'b0) routeParErr = 1'b1;
					if (isSop) state_d = ST_HEAD;
				end
				ST_HEAD: begin
					if (isData) begin
						transLen_d = trans_bytes(rxByte[SIZE_MSB:SIZE_LSB]);
						byteCnt_d = 10'h001;
						crc_d = crc_byte(CRC_INIT, rxByte);
						state_d = ST_BODY;
					end else if (isEop) begin
						state_d = ST_ROUTE;
					end
				end
				ST_BODY: begin
					if (isData) begin
						byteCnt_d = byteCnt_q + 10'h001;
						crc_d = crcNext;
						if (transDone) begin
							state_d = ST_HEAD;
							crcErr = crcNext != CRC_RESIDUE;
						end
					end else if (isEop || isSop) begin
						premature = 1'b1;
						state_d = isEop ? ST_ROUTE : ST_HEAD;
					end
				end
				ST_GOBBLE: begin
					if (isEop) state_d = ST_ROUTE;
				end
			endcase
			if (routeParErr || (crcEn && crcErr)) state_d = ST_GOBBLE;
			if (crcEn && premature) state_d = ST_GOBBLE;
			if ((crcEn && premature && isEop)) state_d = ST_ROUTE;
			if (waitFire && waitCtrl_q[WAIT_NACK_BIT] && state_q != ST_GOBBLE) begin
				waitGobble = 1'b1;
				state_d = isEop ? ST_ROUTE : ST_GOBBLE;
			end
		end
		abortBad = routeParErr || (crcEn && (crcErr || premature)) || (hardReset && inPkt_q);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_ROUTE;
			byteCnt_q <= '0;
			transLen_q <= '0;
			crc_q <= CRC_INIT;
			inPkt_q <= 1'b0;
		end else begin
			state_q <= state_d;
			byteCnt_q <= byteCnt_d;
			transLen_q <= transLen_d;
			crc_q <= crc_d;
			inPkt_q <= inPkt_d;
		end
	end

	// Forwarding: pass through, or bad end as SOP then EOP
	logic badEop_q;
	wire passFwd = (isData || isSop || isEop) && state_q != ST_GOBBLE && !abortBad && !waitGobble && !inLineReset;
	wire fwdValid_d = badEop_q || abortBad || passFwd;
	wire [SYM_W-1:0] fwdSym_d = badEop_q ? CMD_EOP : (abortBad ? CMD_SOP : holdSym_q);
	wire nack_d = (abortBad || waitGobble) && !ackReturned;

	// Error flags: set wins over clear
	logic [ERR_W-1:0] errFlags_q, errSet;
	assign errSet[ERR_PHASE] = phaseErr;
	assign errSet[ERR_DATA] = dataErr;
	assign errSet[ERR_ROUTE_PAR] = routeParErr;
	assign errSet[ERR_CRC] = crcEn && (crcErr || premature);
	assign errSet[ERR_OPEN_TO] = openFire || (waitFire && waitCtrl_q[WAIT_FLAG_BIT]);
	wire [ERR_W-1:0] errFlags_d = (errFlags_q & ~tapErrClr) | errSet;

	// Reset propagation counters
	logic [8:0] creditCnt_q;
	logic [6:0] tokenCnt_q;
	wire [8:0] creditCnt_d = (isRst || hardReset) ? 9'(CREDIT_HOLD_CYCLES) : (creditCnt_q != 9'h000 ? creditCnt_q - 9'h001 : creditCnt_q);
	wire [6:0] tokenCnt_d = xbarResetIn ? 7'(TOKEN_IGNORE_CYCLES) : (tokenCnt_q != 7'h00 ? tokenCnt_q - 7'h01 : tokenCnt_q);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lineCnt_q <= 9'(LINE_RESET_CYCLES);
			creditCnt_q <= 9'(CREDIT_HOLD_CYCLES);
			tokenCnt_q <= '0;
			errFlags_q <= '0;
			badEop_q <= 1'b0;
		end else begin
			lineCnt_q <= lineCnt_d;
			creditCnt_q <= creditCnt_d;
			tokenCnt_q <= tokenCnt_d;
			errFlags_q <= errFlags_d;
			badEop_q <= abortBad;
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fwdValid <= 1'b0;
			fwdSymbol <= CMD_NULL;
			nackToSender <= 1'b0;
			xbarResetOut <= 1'b0;
			inFlush <= 1'b1;
			creditHold <= 1'b1;
			outLinkReset <= 1'b0;
			txResetHold <= 1'b1;
			txResetOnce <= 1'b0;
			creditClear <= 1'b1;
			tokenIgnore <= 1'b0;
			disabledPack <= 1'b0;
			errorN <= 1'b1;
		end else begin
			fwdValid <= fwdValid_d;
			fwdSymbol <= fwdValid_d ? fwdSym_d : CMD_NULL;
			nackToSender <= nack_d;
			xbarResetOut <= isRst && inPkt_q;
			inFlush <= isRst || hardReset;
			creditHold <= creditCnt_d != 9'h000;
			outLinkReset <= openFire;
			txResetHold <= lineCnt_d != 9'h000 || tapLinkDisable || xbarResetIn;
			txResetOnce <= xbarResetIn;
			creditClear <= xbarResetIn || hardReset;
			tokenIgnore <= tokenCnt_d != 7'h00;
			disabledPack <= tapLinkDisable;
			errorN <= ~|errFlags_d;
		end
	end

	assign waitCtrl = waitCtrl_q;
	assign globalCfg = globalCfg_q;
	assign errFlags = errFlags_q;

	// ---------------- Assertions ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	line_reset_hold_a: assert property (hardReset |=> txResetHold [*8]) else $error("link reset too short");
	line_reset_count_a: assert property (hardReset |=> lineCnt_q == 9'(LINE_RESET_CYCLES)) else $error("bad reset count");
	data_err_flag_a: assert property (dataErr |=> errFlags_q[ERR_DATA] && !errorN) else $error("data error lost");
	route_badend_a: assert property (routeParErr && !ackReturned |=> nackToSender && fwdValid
		&& fwdSymbol == CMD_SOP ##1 fwdValid && fwdSymbol == CMD_EOP) else $error("no bad end on parity");
	crc_flag_set_a: assert property (crcEn && premature |=> errFlags_q[ERR_CRC]) else $error("premature end not flagged");
	crc_disabled_a: assert property (!crcEn && !errFlags_q[ERR_CRC] |=> !errFlags_q[ERR_CRC]) else $error("flag while disabled");
	wait_gobble_a: assert property (waitGobble |=> state_q == ST_GOBBLE || state_q == ST_ROUTE ##1 !fwdValid) else $error("gobble leaked");
	wait_flag_only_a: assert property (waitFire && waitCtrl_q == 2'h2 |=> errFlags_q[ERR_OPEN_TO] && !nackToSender) else $error("flag only failed");
	wait_ctrl_reset_a: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=> waitCtrl_q == WAIT_CTRL_RESET)
		else $error("wait control not cleared");
	reset_once_a: assert property (xbarResetIn ##1 !xbarResetIn |-> txResetOnce ##1 !txResetOnce) else $error("reset not single");
	token_ignore_a: assert property (xbarResetIn |=> tokenIgnore [*8]) else $error("tokens not ignored");
	credit_hold_a: assert property (isRst |=> creditHold [*8]) else $error("credit not held");
	sticky_flag_a: assert property (errFlags_q[ERR_CRC] && !tapErrClr[ERR_CRC] |=> errFlags_q[ERR_CRC]) else $error("flag not sticky");

	parity_abort_c: cover property (routeParErr ##2 fwdSymbol == CMD_EOP);
	crc_error_c: cover property (crcEn && crcErr);
	wait_gobble_c: cover property (waitGobble);
	reset_prop_c: cover property (isRst && inPkt_q ##1 xbarResetOut);
endmodule : switch_link_error_handler

// ### rtl/link_err_pkg.sv
package link_err_pkg;
	localparam int SYM_W = 9;
	// Line symbols: commands are {3'h7, code, code}
	localparam logic [8:0] CMD_NULL = 9'h1C0;
	localparam logic [8:0] CMD_SOP = 9'h1D2;
	localparam logic [8:0] CMD_EOP = 9'h1DB;
	localparam logic [8:0] CMD_RESET = 9'h1FF;
	localparam logic [2:0] CMD_TOP = 3'h7;
	localparam logic [2:0] DATA_TOP_0 = 3'h0;
	localparam logic [2:0] DATA_TOP_1 = 3'h1;
	localparam logic [2:0] DATA_TOP_2 = 3'h2;
	localparam logic [2:0] DATA_TOP_3 = 3'h4;
	localparam logic [1:0] BYTE_HI_0 = 2'h0;
	localparam logic [1:0] BYTE_HI_1 = 2'h1;
	localparam logic [1:0] BYTE_HI_2 = 2'h2;
	localparam logic [1:0] BYTE_HI_3 = 2'h3;
	localparam int SIZE_LSB = 4;
	localparam int SIZE_MSB = 6;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int LINE_RESET_CYCLES = 256;
	localparam int TOKEN_IGNORE_CYCLES = 64;
	localparam int CREDIT_HOLD_CYCLES = 256;
	localparam longint OPEN_TIMEOUT_MS = 240;
	localparam longint OPEN_TIMEOUT_CYCLES = (OPEN_TIMEOUT_MS * CLK_HZ) / 1000;
	localparam longint WAIT_BASE_NS = 22000;
	localparam longint WAIT_BASE_CYCLES = (WAIT_BASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Error flag positions
	localparam int ERR_PHASE = 0;
	localparam int ERR_DATA = 1;
	localparam int ERR_ROUTE_PAR = 2;
	localparam int ERR_CRC = 3;
	localparam int ERR_OPEN_TO = 4;
	localparam int ERR_W = 5;
	// Waiting timeout control and global configuration
	localparam int WAIT_NACK_BIT = 0;
	localparam int WAIT_FLAG_BIT = 1;
	localparam logic [1:0] WAIT_CTRL_RESET = 2'h0;
	localparam logic [2:0] WAIT_CODE_RESET = 3'h0;
	localparam int CFG_CRC_DIS_BIT = 3;
	localparam logic [3:0] GLOBAL_CFG_RESET = 4'h0;

	typedef enum {ST_ROUTE, ST_HEAD, ST_BODY, ST_GOBBLE} rx_state_type;

	function automatic logic [9:0] trans_bytes(input logic [2:0] code);
		unique case (code)
			3'h0: trans_bytes = 10'd10;
			3'h1: trans_bytes = 10'd18;
			3'h2: trans_bytes = 10'd26;
			3'h3: trans_bytes = 10'd42;
			3'h4: trans_bytes = 10'd74;
			3'h5: trans_bytes = 10'd138;
			3'h6: trans_bytes = 10'd266;
			3'h7: trans_bytes = 10'd522;
		endcase
	endfunction : trans_bytes
endpackage : link_err_pkg

// ### verification/link_sender.sv
`timescale 1ns/1ns
module link_sender
	import link_err_pkg::*;
(
	input wire logic linkClk,
	output logic [SYM_W-1:0] rxSymbol,
	output logic rxPhaseSlip
);
	initial begin
		rxSymbol = CMD_NULL;
		rxPhaseSlip = 1'b0;
	end
	// Idle NULLs after each symbol let the core handshake finish
	task automatic send(input logic [SYM_W-1:0] sym);
		@(posedge linkClk);
		rxSymbol <= sym;
		@(posedge linkClk);
		rxSymbol <= CMD_NULL;
		repeat (200) @(posedge linkClk);
	endtask : send
	task automatic send_byte(input logic [7:0] b);
		logic [2:0] top [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
		send({top[b[7:6]], b[5:0]});
	endtask : send_byte
	// A timed-out sender clears its packet with the reset command
	task automatic clear_packet();
		send(CMD_RESET);
	endtask : clear_packet
	task automatic slip();
		@(posedge linkClk);
		rxPhaseSlip <= 1'b1;
		@(posedge linkClk);
		rxPhaseSlip <= 1'b0;
	endtask : slip
endmodule : link_sender

// ### verification/test_switch_link_error_handler.sv
`timescale 1ns/1ns
module test_switch_link_error_handler;
	import link_err_pkg::*;
	typedef logic [7:0] byte_q_type [$];
	localparam int TXH = 0, CRH = 1, IGN = 2, FL = 3, XB = 4, ORS = 5, CLR = 6, ONCE = 7, NK = 8;
	logic clk, rst_n, linkClk, inputOpen, inputWaiting, ackReturned, xbarResetIn;
	logic tapWaitCtrlWe, tapGlobalWe, tapLinkReset, tapLinkDisable, rxPhaseSlip, fwdValid;
	logic nackToSender, xbarResetOut, inFlush, creditHold, outLinkReset, errorN;
	logic txResetHold, txResetOnce, creditClear, tokenIgnore, disabledPack;
	logic [1:0] tapWaitCtrlIn, waitCtrl;
	logic [3:0] tapGlobalIn, globalCfg;
	logic [ERR_W-1:0] tapErrClr, errFlags;
	logic [SYM_W-1:0] rxSymbol, fwdSymbol;
	logic [SYM_W-1:0] fwdQ [$];
	int failures, comparisons;
	int cnt [9];
	int seed = 32'h2b2b;
	int sizeTab [8] = '{10, 18, 26, 42, 74, 138, 266, 522};
	wire [8:0] mon = {nackToSender, txResetOnce, creditClear, outLinkReset, xbarResetOut, inFlush,
		tokenIgnore, creditHold, txResetHold};

	switch_link_error_handler #(.OPEN_LIMIT(50), .WAIT_BASE(4)) switch_link_error_handler_inst (.clk, .rst_n,
		.linkClk, .rxSymbol, .rxPhaseSlip, .inputOpen, .inputWaiting, .ackReturned, .xbarResetIn,
		.tapWaitCtrlWe, .tapWaitCtrlIn, .tapGlobalWe, .tapGlobalIn, .tapErrClr, .tapLinkReset,
		.tapLinkDisable, .fwdValid, .fwdSymbol, .nackToSender, .xbarResetOut, .inFlush, .creditHold,
		.outLinkReset, .txResetHold, .txResetOnce, .creditClear, .tokenIgnore, .disabledPack, .waitCtrl,
		.globalCfg, .errFlags, .errorN);
	link_sender link_sender_inst (.linkClk, .rxSymbol, .rxPhaseSlip);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		linkClk = 1'b0;
		#2;
		forever #3 linkClk = ~linkClk;
	end
	always @(posedge clk) begin
		foreach (cnt[i]) cnt[i] += int'(mon[i] === 1'b1);
		if (fwdValid === 1'b1) fwdQ.push_back(fwdSymbol);
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic zero();
		@(negedge clk);
		foreach (cnt[i]) cnt[i] = 0;
		fwdQ.delete();
		@(posedge clk);
	endtask : zero
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			failures++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic final_report();
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	task automatic wait_flag(input int idx);
		int k;
		for (k = 0; k < 600 && errFlags[idx] !== 1'b1; k++) @(posedge clk);
		if (k == 600) begin
			check(1'b0, "flag never set");
			final_report();
		end
	endtask : wait_flag
	task automatic tap(input logic [1:0] w, input logic [3:0] g, input logic [4:0] c);
		@(posedge clk);
		tapWaitCtrlWe <= 1'b1;
		tapWaitCtrlIn <= w;
		tapGlobalWe <= 1'b1;
		tapGlobalIn <= g;
		tapErrClr <= c;
		@(posedge clk);
		tapWaitCtrlWe <= 1'b0;
		tapGlobalWe <= 1'b0;
		tapErrClr <= '0;
		cyc(2);
	endtask : tap
	function automatic logic [15:0] crc16(input byte_q_type d);
		logic [15:0] c = CRC_INIT;
		foreach (d[i]) begin
			for (int b = 7; b >= 0; b--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i][b]) ? CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction : crc16
	function automatic logic [7:0] good_route();
		logic [7:0] r = 8'($random(seed));
		r[0] = ~^r[7:1];
		return r;
	endfunction : good_route
	task automatic packet(input logic [7:0] route, input logic [2:0] code, input int cut, input logic bad);
		byte_q_type t;
		logic [15:0] c;
		t.push_back({1'b0, code, 4'($random(seed))});
		repeat (sizeTab[code] - 3) t.push_back(8'($random(seed)));
		c = crc16(t);
		t.push_back(c[15:8]);
		t.push_back(c[7:0] ^ {7'h00, bad});
		link_sender_inst.send_byte(route);
		link_sender_inst.send(CMD_SOP);
		foreach (t[i]) begin
			if (i < cut) link_sender_inst.send_byte(t[i]);
		end
		link_sender_inst.send(CMD_EOP);
	endtask : packet

	initial begin
		cyc(90000);
		check(1'b0, "run timed out");
		final_report();
	end
	initial begin
		{rst_n, inputOpen, inputWaiting, ackReturned, xbarResetIn, tapLinkReset, tapLinkDisable} = '0;
		{tapWaitCtrlWe, tapWaitCtrlIn, tapGlobalWe, tapGlobalIn, tapErrClr} = '0;
		cyc(5);
		check(errFlags === 5'h00 && errorN === 1'b1 && txResetHold === 1'b1, "reset outputs");
		check(waitCtrl === 2'h0 && globalCfg === 4'h0, "config reset");
		cyc(15);
		rst_n <= 1'b1;
		cyc(300);
		for (int c = 0; c < 8; c++) begin
			packet(good_route(), c[2:0], 999, 1'b0);
			cyc(20);
			check(errFlags === 5'h00, "good packet flagged");
		end
		zero();
		packet(good_route(), 3'h1, 999, 1'b1);
		wait_flag(ERR_CRC);
		check(cnt[NK] >= 1 && errorN === 1'b0, "crc abort");
		tap(2'h0, 4'h0, 5'h1F);
		check(errFlags === 5'h00 && errorN === 1'b1, "flag clear");
		ackReturned <= 1'b1;
		zero();
		packet(good_route(), 3'h0, 999, 1'b1);
		wait_flag(ERR_CRC);
		check(cnt[NK] === 0, "nack after ack");
		ackReturned <= 1'b0;
		tap(2'h0, 4'h0, 5'h1F);
		packet(good_route(), 3'h2, 7, 1'b0);
		wait_flag(ERR_CRC);
		tap(2'h0, 4'h8, 5'h1F);
		packet(good_route(), 3'h1, 999, 1'b1);
		cyc(30);
		check(errFlags === 5'h00, "crc flag disabled");
		tap(2'h0, 4'h0, 5'h1F);
		zero();
		packet(good_route() ^ 8'h80, 3'h0, 999, 1'b0);
		wait_flag(ERR_ROUTE_PAR);
		check(errFlags === 5'h04 && cnt[NK] === 1, "route parity");
		check(fwdQ[0] === CMD_SOP && fwdQ[1] === CMD_EOP, "bad end marker");
		tap(2'h0, 4'h0, 5'h1F);
		for (int k = 0; k < 2; k++) begin
			zero();
			if (k == 0) link_sender_inst.send(9'h0C0);
			else link_sender_inst.slip();
			wait_flag(k == 0 ? ERR_DATA : ERR_PHASE);
			cyc(400);
			check(cnt[TXH] >= 256 && cnt[FL] >= 1, "line error reset");
			tap(2'h0, 4'h0, 5'h1F);
		end
		for (int k = 0; k < 2; k++) begin
			tap(k == 0 ? 2'h2 : 2'h1, 4'h0, 5'h1F);
			zero();
			inputWaiting <= 1'b1;
			cyc(40);
			inputWaiting <= 1'b0;
			if (k == 0) check(errFlags === 5'h10 && cnt[NK] === 0, "wait flag only");
			else check(errFlags === 5'h00 && cnt[NK] >= 1 && fwdQ.size() == 0, "wait gobble");
		end
		tap(2'h2, 4'h3, 5'h1F);
		inputWaiting <= 1'b1;
		cyc(20);
		check(errFlags[ERR_OPEN_TO] === 1'b0, "wait period short");
		cyc(60);
		check(errFlags[ERR_OPEN_TO] === 1'b1, "wait period long");
		inputWaiting <= 1'b0;
		tap(2'h0, 4'h0, 5'h1F);
		zero();
		inputOpen <= 1'b1;
		cyc(120);
		inputOpen <= 1'b0;
		check(cnt[ORS] >= 1 && errFlags === 5'h10, "open timeout");
		tap(2'h0, 4'h0, 5'h1F);
		cyc(300);
		zero();
		inputOpen <= 1'b1;
		link_sender_inst.send_byte(good_route());
		link_sender_inst.send(CMD_SOP);
		link_sender_inst.clear_packet();
		inputOpen <= 1'b0;
		cyc(600);
		check(cnt[XB] === 1 && cnt[FL] >= 1, "reset forwarded");
		check(cnt[CRH] >= 256 && cnt[CRH] <= 512, "credit hold");
		check(cnt[TXH] === 0, "reverse direction reset");
		zero();
		xbarResetIn <= 1'b1;
		cyc(1);
		xbarResetIn <= 1'b0;
		cyc(300);
		check(cnt[ONCE] === 1 && cnt[CLR] >= 1 && cnt[TXH] >= 1, "single reset command");
		check(cnt[IGN] >= 64 && cnt[IGN] <= 128, "credit ignore");
		tapLinkDisable <= 1'b1;
		cyc(10);
		check(txResetHold === 1'b1 && disabledPack === 1'b1, "disabled link");
		tapLinkDisable <= 1'b0;
		cyc(300);
		zero();
		tapLinkReset <= 1'b1;
		cyc(1);
		tapLinkReset <= 1'b0;
		cyc(400);
		check(cnt[TXH] >= 256 && cnt[FL] >= 1, "test port reset");
		tap(2'h3, 4'h5, 5'h00);
		check(waitCtrl === 2'h3 && globalCfg === 4'h5, "config readback");
		rst_n <= 1'b0;
		cyc(20);
		check(waitCtrl === 2'h0 && globalCfg === 4'h0 && errFlags === 5'h00, "chip reset");
		rst_n <= 1'b1;
		final_report();
	end
endmodule : test_switch_link_error_handler
